/* File: occ_defines.svh */
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// Chain length and field positions (bit index in the shift chain)
`define OCC_CHAIN_LEN      53
`define OCC_POS_BASE       45
`define OCC_POS_SLOPE_D    42
`define OCC_POS_SLOPE_C    39
`define OCC_POS_SLOPE_B    36
`define OCC_POS_SLOPE_A    33
`define OCC_POS_PUMP       31
`define OCC_POS_BIAS       28
`define OCC_POS_DEFSEL     27
`define OCC_POS_TRIM       21
`define OCC_POS_GREY_FR    18
`define OCC_POS_GREY_TUNE  15
`define OCC_POS_MONO_FR    12
`define OCC_POS_MONO_TUNE  9
`define OCC_POS_LINE_INV   2
`define OCC_POS_FRAME_INV  1
`define OCC_POS_SEAL       0

// Command byte codes
`define OCC_CMD_CALIB_TOP  6'h3C
`define OCC_CMD_DON_TOP    7'h57
`define OCC_CMD_LOAD0      8'hD8
`define OCC_CMD_LOAD1      8'hD9

// Register offsets
`define OCC_REG_BASE       4'h0
`define OCC_REG_SLOPES     4'h1
`define OCC_REG_PUMP_BIAS  4'h2
`define OCC_REG_GREY       4'h3
`define OCC_REG_MONO       4'h4
`define OCC_REG_INVERT     4'h5
`define OCC_REG_STATUS     4'h8
`define OCC_REG_DRIVE      4'h9
`define OCC_REG_TRIM       4'hA

// Reset values
`define OCC_RST_CFG        16'h0000
`define OCC_RST_WORD       8'h00

// Drive word range and timing
`define OCC_DRIVE_MAX      10'sh0FF
`define OCC_REFRESH_US     5000
`define OCC_CLK_MHZ        100

`endif

/* File: occ_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"
module occ_host_model
(
  input  wire logic       clk_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_byte_o
);
  // Idle bus holds the inverse of the last byte, so stale data never looks fresh
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_byte_o  = 8'h00;
  end

  // One command per strobe, changed just after a rising edge
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o  <= b;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o  <= ~b;
  endtask

  // whole chain shifted
  // First bit sent ends at the base MSB end; a partial chain would misplace fields
  task automatic shift_word(input logic [52:0] w);
    for (int i = 52; i >= 0; i--)
    begin
      send(w[i] ? `OCC_CMD_LOAD1 : `OCC_CMD_LOAD0);
    end
  endtask
endmodule
`default_nettype wire

/* File: occ_otp_config.sv */
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"
module occ_otp_config
  import occ_pkg::*;
#(
  parameter int REFRESH_CYCLES = `OCC_REFRESH_US * `OCC_CLK_MHZ
)
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic [7:0]  CMD_BYTE_I,
  input  wire logic        POWER_DOWN_I,
  input  wire logic        PROG_VOLTAGE_I,
  input  wire logic [7:0]  TEMP_OFFSET_I,
  input  wire logic [3:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [15:0] REG_RDATA_O,
  output logic      [7:0]  DRIVE_VOLTAGE_WORD_O,
  output logic      [7:0]  BASE_VOLTAGE_CODE_O,
  output logic      [11:0] SLOPES_O,
  output logic      [1:0]  PUMP_FACTOR_O,
  output logic      [2:0]  BIAS_LEVEL_SEL_O,
  output logic      [2:0]  GREY_FRAME_RANGE_O,
  output logic      [2:0]  GREY_OSC_TUNE_O,
  output logic      [2:0]  MONO_FRAME_RATE_O,
  output logic      [2:0]  MONO_OSC_TUNE_O,
  output logic      [6:0]  LINE_INVERSION_COUNT_O,
  output logic             FRAME_INVERSION_O,
  output logic             CALIB_MODE_O,
  output logic             PROG_GATE_O
);
  localparam int CL = `OCC_CHAIN_LEN;
  localparam int RW = $clog2(REFRESH_CYCLES + 1);
  localparam logic [RW-1:0] REF_LAST = RW'(REFRESH_CYCLES - 1);

  logic [CL-1:0]  chain;
  logic [CL-1:0]  cells;
  logic           calib_mode;
  logic           program_switch_enable;
  logic           seal_valid;
  occ_ref_state_t ref_state;
  logic [RW-1:0]  ref_cnt;
  logic [7:0]     host_base;
  logic [11:0]    host_slopes;
  logic [4:0]     host_pump_bias;
  logic [5:0]     host_grey;
  logic [5:0]     host_mono;
  logic [7:0]     host_invert;
  logic [7:0]     drive_voltage_word;

  // Command decode
  wire cmd_calib = CMD_VALID_I && (CMD_BYTE_I[7:2] == `OCC_CMD_CALIB_TOP);
  wire cmd_don   = CMD_VALID_I && (CMD_BYTE_I[7:1] == `OCC_CMD_DON_TOP);
  wire cmd_load  = CMD_VALID_I && ((CMD_BYTE_I == `OCC_CMD_LOAD0) ||
                                   (CMD_BYTE_I == `OCC_CMD_LOAD1));

  // Chain fields
  wire       otp_default_select = chain[`OCC_POS_DEFSEL];
  wire       seal               = chain[`OCC_POS_SEAL];
  wire [5:0] vlcd_trim_code     = chain[`OCC_POS_TRIM +: 6];

  wire calib_allowed = seal_valid && !seal;
  wire shift_en      = calib_mode && cmd_load;
  wire reload        = (ref_state == OCC_RF_RUN) && !POWER_DOWN_I && (ref_cnt == REF_LAST);
  wire program_en    = calib_mode && program_switch_enable && PROG_VOLTAGE_I;

  // chain order, new bit at seal end
  genvar g;
  generate
    for (g = 0; g < CL; g++)
    begin : g_slice
      occ_otp_slice u_slice
      (
        .clk_i      (CLK_SYS_I),
        .rst_n_i    (RST_N_I),
        .reload_i   (reload),
        .shift_i    (shift_en),
        .shift_in_i ((g == 0) ? CMD_BYTE_I[0] : chain[(g == 0) ? 0 : g - 1]),
        .program_i  (program_en),
        .q_o        (chain[g]),
        .cell_o     (cells[g])
      );
    end
  endgenerate

  // Calibration mode and switch enable; refused commands change nothing
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      calib_mode            <= 1'b0;
      program_switch_enable <= 1'b0;
    end
    else if (cmd_calib && (calib_mode || calib_allowed))
    begin
      calib_mode            <= CMD_BYTE_I[0];
      program_switch_enable <= CMD_BYTE_I[0] & CMD_BYTE_I[1];
    end
  end

  // Refresh sequencer; a new request restarts the wait, but requests made in calibration mode are dropped
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ref_state  <= OCC_RF_IDLE;
      ref_cnt    <= '0;
      seal_valid <= 1'b0;
    end
    else if (cmd_don && !calib_mode)
    begin
      ref_state <= OCC_RF_RUN;
      ref_cnt   <= '0;
    end
    else
    begin
      unique case (ref_state)
        OCC_RF_IDLE: ref_cnt <= '0;
        OCC_RF_RUN:
        begin
          // Counting holds while powered down
          if (reload)
          begin
            ref_state  <= OCC_RF_IDLE;
            seal_valid <= 1'b1;
          end
          else if (!POWER_DOWN_I)
            ref_cnt <= ref_cnt + 1'b1;
        end
      endcase
    end
  end

  // Host configuration write decode
  // writes dropped while cells supply defaults
  wire wr_ok     = REG_WR_I && !otp_default_select;
  wire wr_base   = wr_ok && (REG_ADDR_I == `OCC_REG_BASE);
  wire wr_slopes = wr_ok && (REG_ADDR_I == `OCC_REG_SLOPES);
  wire wr_pb     = wr_ok && (REG_ADDR_I == `OCC_REG_PUMP_BIAS);
  wire wr_grey   = wr_ok && (REG_ADDR_I == `OCC_REG_GREY);
  wire wr_mono   = wr_ok && (REG_ADDR_I == `OCC_REG_MONO);
  wire wr_inv    = wr_ok && (REG_ADDR_I == `OCC_REG_INVERT);

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      host_base      <= `OCC_RST_WORD;
      host_slopes    <= 12'(`OCC_RST_CFG);
      host_pump_bias <= 5'(`OCC_RST_CFG);
      host_grey      <= 6'(`OCC_RST_CFG);
      host_mono      <= 6'(`OCC_RST_CFG);
      host_invert    <= 8'(`OCC_RST_CFG);
    end
    else
    begin
      if (wr_base)
        host_base <= REG_WDATA_I[7:0];
      if (wr_slopes)
        host_slopes <= REG_WDATA_I[11:0];
      if (wr_pb)
        host_pump_bias <= REG_WDATA_I[4:0];
      if (wr_grey)
        host_grey <= REG_WDATA_I[5:0];
      if (wr_mono)
        host_mono <= REG_WDATA_I[5:0];
      if (wr_inv)
        host_invert <= REG_WDATA_I[7:0];
    end
  end

  // host source when select is 0
  // cell source when select is 1
  wire [7:0]  base_voltage_code = otp_default_select ? chain[`OCC_POS_BASE +: 8] : host_base;
  wire [11:0] slopes_sel = otp_default_select ?
    {chain[`OCC_POS_SLOPE_D +: 3], chain[`OCC_POS_SLOPE_C +: 3],
     chain[`OCC_POS_SLOPE_B +: 3], chain[`OCC_POS_SLOPE_A +: 3]} : host_slopes;
  wire [4:0]  pb_sel   = otp_default_select ?
    {chain[`OCC_POS_BIAS +: 3], chain[`OCC_POS_PUMP +: 2]} : host_pump_bias;
  wire [5:0]  grey_sel = otp_default_select ?
    {chain[`OCC_POS_GREY_TUNE +: 3], chain[`OCC_POS_GREY_FR +: 3]} : host_grey;
  wire [5:0]  mono_sel = otp_default_select ?
    {chain[`OCC_POS_MONO_TUNE +: 3], chain[`OCC_POS_MONO_FR +: 3]} : host_mono;
  wire [7:0]  inv_sel  = otp_default_select ?
    {chain[`OCC_POS_FRAME_INV], chain[`OCC_POS_LINE_INV +: 7]} : host_invert;

  // base plus trim plus temperature offset
  // ten-bit signed sum cannot overflow before the clamp
  wire signed [9:0] drive_sum = $signed({2'b00, base_voltage_code})
                              + $signed({{4{vlcd_trim_code[5]}}, vlcd_trim_code})
                              + $signed({{2{TEMP_OFFSET_I[7]}}, TEMP_OFFSET_I});
  wire [7:0] drive_clamped = (drive_sum > `OCC_DRIVE_MAX) ? 8'hFF :
                             (drive_sum < 10'sh000) ? 8'h00 : drive_sum[7:0];

  // Drive voltage word registered
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      drive_voltage_word <= `OCC_RST_WORD;
    else
      drive_voltage_word <= drive_clamped;
  end

  // Read mux; unmapped offsets read zero
  wire [15:0] status = {10'h000, (ref_state == OCC_RF_RUN), seal_valid, seal,
                        otp_default_select, program_switch_enable, calib_mode};
  logic [15:0] next_rdata;
  always_comb
  begin
    unique case (REG_ADDR_I)
      `OCC_REG_BASE:      next_rdata = {8'h00, base_voltage_code};
      `OCC_REG_SLOPES:    next_rdata = {4'h0, slopes_sel};
      `OCC_REG_PUMP_BIAS: next_rdata = {11'h000, pb_sel};
      `OCC_REG_GREY:      next_rdata = {10'h000, grey_sel};
      `OCC_REG_MONO:      next_rdata = {10'h000, mono_sel};
      `OCC_REG_INVERT:    next_rdata = {8'h00, inv_sel};
      `OCC_REG_STATUS:    next_rdata = status;
      `OCC_REG_DRIVE:     next_rdata = {8'h00, drive_voltage_word};
      `OCC_REG_TRIM:      next_rdata = {10'h000, vlcd_trim_code};
      default:            next_rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      REG_RDATA_O <= 16'h0000;
    else
      REG_RDATA_O <= REG_RD_I ? next_rdata : 16'h0000;
  end

  // Configuration outputs, all from flip-flops or their selection
  assign DRIVE_VOLTAGE_WORD_O   = drive_voltage_word;
  assign BASE_VOLTAGE_CODE_O    = base_voltage_code;
  assign SLOPES_O               = slopes_sel;
  assign PUMP_FACTOR_O          = pb_sel[1:0];
  assign BIAS_LEVEL_SEL_O       = pb_sel[4:2];
  assign GREY_FRAME_RANGE_O     = grey_sel[2:0];
  assign GREY_OSC_TUNE_O        = grey_sel[5:3];
  assign MONO_FRAME_RATE_O      = mono_sel[2:0];
  assign MONO_OSC_TUNE_O        = mono_sel[5:3];
  assign LINE_INVERSION_COUNT_O = inv_sel[6:0];
  assign FRAME_INVERSION_O      = inv_sel[7];
  assign CALIB_MODE_O           = calib_mode;
  assign PROG_GATE_O            = calib_mode & program_switch_enable;

  // Assertions
  sequence s_refresh_done;
    reload ##1 1'b1;
  endsequence

  a_clamp_high: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (drive_sum > `OCC_DRIVE_MAX) |=> (DRIVE_VOLTAGE_WORD_O == 8'hFF))
    else $error("drive word not clamped high");

  a_clamp_low: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (drive_sum < 10'sh000) |=> (DRIVE_VOLTAGE_WORD_O == 8'h00))
    else $error("drive word not clamped low");

  a_seal_refuse: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (cmd_calib && seal && !calib_mode) |=> !CALIB_MODE_O)
    else $error("calibration entered with seal set");

  a_entry_armed: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!seal_valid && !calib_mode) |=> !CALIB_MODE_O)
    else $error("calibration entered before refresh");

  a_seal_sticky: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    cells[`OCC_POS_SEAL] |=> cells[`OCC_POS_SEAL])
    else $error("seal cell cleared");

  a_cells_hold: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !calib_mode |=> $stable(cells))
    else $error("cells changed outside calibration");

  a_shift_bit: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    shift_en |=> (chain[0] == $past(CMD_BYTE_I[0])) && (chain[CL-1:1] == $past(chain[CL-2:0])))
    else $error("load command did not shift one bit");

  a_reload_copy: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s_refresh_done |-> (chain == $past(cells)))
    else $error("refresh did not copy cells");

  a_host_blocked: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (REG_WR_I && otp_default_select && !reload && !shift_en) |=> $stable(host_base))
    else $error("host write taken with cell defaults");

  a_source_host: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !otp_default_select |-> (BASE_VOLTAGE_CODE_O == host_base) && (SLOPES_O == host_slopes))
    else $error("host source not selected");
endmodule
`default_nettype wire

/* File: occ_otp_slice.sv */
`timescale 1ns/1ps
`default_nettype none
module occ_otp_slice
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic reload_i,
  input  wire logic shift_i,
  input  wire logic shift_in_i,
  input  wire logic program_i,
  output logic      q_o,
  output logic      cell_o
);
  // Cell only ever gains ones, copied from its own flip-flop
  // ones cleared only by reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cell_o <= 1'b0;
    else if (program_i)
      cell_o <= cell_o | q_o;
  end

  // Flip-flop is the only path in or out of the cell
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= 1'b0;
    else if (reload_i)
      q_o <= cell_o;
    else if (shift_i)
      q_o <= shift_in_i;
  end
endmodule
`default_nettype wire

/* File: occ_pkg.sv */
package occ_pkg;
  typedef enum logic [0:0] {
    OCC_RF_IDLE = 1'b0,
    OCC_RF_RUN  = 1'b1
  } occ_ref_state_t;
endpackage

/* File: test_otp_calibration_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"
module test_otp_calibration_config
  import occ_pkg::*;
;
  localparam int RC = 16;
  logic        clk;
  logic        rst_n;
  logic        pd;
  logic        pv;
  logic        cmd_v;
  logic [7:0]  cmd_b;
  logic [7:0]  temp;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [7:0]  drive;
  logic [7:0]  base;
  logic [11:0] slopes;
  logic [1:0]  pump;
  logic [2:0]  bias;
  logic [2:0]  grey_frame_range;
  logic [2:0]  gt;
  logic [2:0]  mfr;
  logic [2:0]  mt;
  logic [6:0]  linv;
  logic        finv;
  logic        calm;
  logic        pgate;
  int          n_errors;
  int          samples_checked;
  logic [7:0]  t_base [4] = '{8'hFA, 8'h14, 8'h80, 8'h64};
  logic [7:0]  t_temp [4] = '{8'h28, 8'h00, 8'h00, 8'h05};
  logic [7:0]  t_exp  [4] = '{8'hFF, 8'h00, 8'h60, 8'h49};

  occ_otp_config #(.REFRESH_CYCLES(RC)) u_occ_otp_config
  (
    .CLK_SYS_I              (clk),
    .RST_N_I                (rst_n),
    .CMD_VALID_I            (cmd_v),
    .CMD_BYTE_I             (cmd_b),
    .POWER_DOWN_I           (pd),
    .PROG_VOLTAGE_I         (pv),
    .TEMP_OFFSET_I          (temp),
    .REG_ADDR_I             (addr),
    .REG_WDATA_I            (wdata),
    .REG_WR_I               (wr),
    .REG_RD_I               (rd),
    .REG_RDATA_O            (rdata),
    .DRIVE_VOLTAGE_WORD_O   (drive),
    .BASE_VOLTAGE_CODE_O    (base),
    .SLOPES_O               (slopes),
    .PUMP_FACTOR_O          (pump),
    .BIAS_LEVEL_SEL_O       (bias),
    .GREY_FRAME_RANGE_O     (grey_frame_range),
    .GREY_OSC_TUNE_O        (gt),
    .MONO_FRAME_RATE_O      (mfr),
    .MONO_OSC_TUNE_O        (mt),
    .LINE_INVERSION_COUNT_O (linv),
    .FRAME_INVERSION_O      (finv),
    .CALIB_MODE_O           (calm),
    .PROG_GATE_O            (pgate)
  );

  occ_host_model u_occ_host_model
  (
    .clk_i       (clk),
    .cmd_valid_o (cmd_v),
    .cmd_byte_o  (cmd_b)
  );

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Comparison of a port value
  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t port %h expected %h", $time, got, exp);
    end
  endtask

  // Register write: one strobe cycle, never waits
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Register read: data stands only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    samples_checked++;
    if (rdata !== exp)
    begin
      n_errors++;
      $display("BAD %0t reg %h read %h expected %h", $time, a, rdata, exp);
    end
  endtask

  // Let registered outputs land before looking
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Refresh count plus margin for the reload edge
  task automatic wait_refresh();
    repeat (RC + 4) @(posedge clk);
  endtask

  task automatic t_reset();
    chk_port(16'(drive), 16'h0000);
    chk_reg(`OCC_REG_STATUS, 16'h0000);
    u_occ_host_model.send(8'hF1);
    settle();
    chk_port(16'(calm), 16'h0000);
  endtask

  // Refresh held back by power-down, then completes within its count
  task automatic t_refresh();
    @(posedge clk);
    pd <= 1'b1;
    u_occ_host_model.send(8'hAF);
    repeat (RC + 8) @(posedge clk);
    chk_reg(`OCC_REG_STATUS, 16'h0020);
    @(posedge clk);
    pd <= 1'b0;
    wait_refresh();
    chk_reg(`OCC_REG_STATUS, 16'h0010);
  endtask

  task automatic t_host();
    reg_wr(`OCC_REG_BASE, 16'h0080);
    reg_wr(`OCC_REG_SLOPES, 16'h0ABC);
    reg_wr(`OCC_REG_PUMP_BIAS, 16'h0016);
    reg_wr(`OCC_REG_GREY, 16'h002A);
    reg_wr(`OCC_REG_MONO, 16'h0019);
    reg_wr(`OCC_REG_INVERT, 16'h00AA);
    reg_wr(`OCC_REG_DRIVE, 16'hFFFF);
    settle();
    chk_port(16'(base), 16'h0080);
    chk_port(16'(slopes), 16'h0ABC);
    chk_port(16'({bias, pump}), 16'h0016);
    chk_port(16'({gt, grey_frame_range, mt, mfr}), 16'h0A99);
    chk_port(16'({finv, linv}), 16'h00AA);
    chk_reg(`OCC_REG_SLOPES, 16'h0ABC);
    chk_reg(`OCC_REG_DRIVE, 16'h0080);
    chk_reg(4'h7, 16'h0000);
  endtask

  // Most negative trim against clamps at both ends
  task automatic t_calib();
    u_occ_host_model.send(8'hF1);
    settle();
    chk_port(16'({calm, pgate}), 16'h0002);
    u_occ_host_model.shift_word({25'h0, 1'b0, 6'h20, 21'h0});
    chk_reg(`OCC_REG_TRIM, 16'h0020);
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(`OCC_REG_BASE, 16'(t_base[i]));
      temp <= t_temp[i];
      settle();
      chk_port(16'(drive), 16'(t_exp[i]));
    end
    temp <= 8'h00;
    u_occ_host_model.send(8'hF0);
    settle();
    chk_port(16'(calm), 16'h0000);
  endtask

  // Stored defaults take over and host writes bounce off
  task automatic t_defaults();
    u_occ_host_model.send(8'hF1);
    u_occ_host_model.shift_word({8'hA5, 12'h9C3, 2'h2, 3'h5, 1'b1, 6'h20,
                                 3'h1, 3'h2, 3'h3, 3'h4, 7'h55, 1'b1, 1'b0});
    u_occ_host_model.send(8'hF0);
    reg_wr(`OCC_REG_BASE, 16'h0011);
    settle();
    chk_port(16'(base), 16'h00A5);
    chk_port(16'(slopes), 16'h09C3);
    chk_port(16'({bias, pump}), 16'h0016);
    chk_port(16'({grey_frame_range, gt, mfr, mt}), 16'h029C);
    chk_port(16'({finv, linv}), 16'h00D5);
    chk_port(16'(drive), 16'h0085);
    chk_reg(`OCC_REG_STATUS, 16'h0014);
  endtask

  // Programming voltage outside calibration must not touch the cells
  task automatic t_stray_prog();
    @(posedge clk);
    pv <= 1'b1;
    repeat (4) @(posedge clk);
    pv <= 1'b0;
    u_occ_host_model.send(8'hAF);
    wait_refresh();
    settle();
    chk_port(16'(base), 16'h0064);
    chk_reg(`OCC_REG_STATUS, 16'h0010);
  endtask

  // Burn the seal, reload it, then calibration entry is refused
  task automatic t_seal();
    u_occ_host_model.send(8'hF3);
    settle();
    chk_port(16'(pgate), 16'h0001);
    u_occ_host_model.shift_word(53'h1);
    pv <= 1'b1;
    repeat (3) @(posedge clk);
    pv <= 1'b0;
    u_occ_host_model.send(8'hF0);
    u_occ_host_model.send(8'hAF);
    wait_refresh();
    chk_reg(`OCC_REG_STATUS, 16'h0018);
    u_occ_host_model.send(8'hF1);
    settle();
    chk_port(16'(calm), 16'h0000);
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a three-cycle reset
  initial
  begin
    rst_n = 1'b0;
    pd = 1'b0;
    pv = 1'b0;
    temp = 8'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_refresh();
    t_host();
    t_calib();
    t_defaults();
    t_stray_prog();
    t_seal();
    end_sim();
  end

  // Watchdog well past the few hundred cycles the run needs
  initial
  begin
    #100000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
